// >>> src/timer_control_status_regs.sv
// Control and status registers of the 16-bit timer, reached over APB
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module timer_control_status_regs
  import timer_regs_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  // System power state, timer mode and edge selection
  input  wire logic              deep_stop_in,
  input  wire logic              low_speed_mode_in,
  input  wire logic              low_freq_tick_in,
  input  wire logic [2:0]        timer_mode_in,
  input  wire logic              double_edge_in,
  // Datapath events and input pin
  input  wire timer_events_t     events_in,
  input  wire logic              timer_pin_in,
  // Datapath control and counter
  output timer_ctrl_t            ctrl_out,
  output logic [15:0]            count_out,
  output logic                   filtered_pin_out,
  output logic                   timer_irq_out,
  output logic                   irq_out
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic [ADDR_W-3:0] word_index;
  logic              access;
  logic              wr_en;
  logic              rd_en;
  logic              hit;

  assign word_index = paddr_in[ADDR_W-1:2];
  assign access     = psel_in && penable_in && pready_out;
  assign wr_en      = access && pwrite_in && pstrb_in[0];
  assign rd_en      = access && !pwrite_in;

  always_comb begin
    case (word_index[7:0])
      CTRL_INDEX, FLAGS_INDEX, IRQ_STAT_INDEX,
      IRQ_EN_INDEX, IRQ_CLR_INDEX, EVENT_INDEX: hit = (word_index[ADDR_W-3:8] == '0);
      default: hit = 1'b0;
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
    end
  end

  // Error answer travels with ready for an address outside the map
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= psel_in && !penable_in && !hit;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  logic       run_reg;
  logic       auto_reg;
  logic [1:0] nc_reg;
  logic       ff_reg;
  logic       ove_reg;
  logic       ctrl_wr;

  assign ctrl_wr = wr_en && hit && word_index[7:0] == CTRL_INDEX;

  // Run bit: deep stop wins over a write in the same cycle
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= CTRL_RESET[CTRL_RUN_POS];
    end else if (deep_stop_in) begin
      run_reg <= 1'b0;
    end else if (ctrl_wr) begin
      run_reg <= pwdata_in[CTRL_RUN_POS];
    end
  end

  // Shared capture/one-shot bit stays writable while running
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      auto_reg <= CTRL_RESET[CTRL_AUTO_POS];
    end else if (ctrl_wr) begin
      auto_reg <= pwdata_in[CTRL_AUTO_POS];
    end
  end

  // Locked fields: a running timer must not see its filter or level move under it
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nc_reg  <= CTRL_RESET[CTRL_NC_LSB +: 2];
      ff_reg  <= CTRL_RESET[CTRL_FF_POS];
      ove_reg <= CTRL_RESET[CTRL_OVE_POS];
    end else if (ctrl_wr && !run_reg) begin
      nc_reg  <= pwdata_in[CTRL_NC_LSB +: 2];
      ff_reg  <= pwdata_in[CTRL_FF_POS];
      ove_reg <= pwdata_in[CTRL_OVE_POS];
    end
  end

  // ==========================================================================
  // Up counter; cleared only while stopped, an overflow event does not touch it
  // ==========================================================================
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_out <= COUNT_RESET;
    end else if (!run_reg) begin
      count_out <= COUNT_RESET;
    end else begin
      count_out <= count_out + 16'h0001;
    end
  end

  // ==========================================================================
  // Noise filter sampling
  // ==========================================================================
  logic [7:0] nc_div_reg;
  logic [7:0] nc_limit;
  logic       nc_tick;
  logic       nc_halt;
  logic [1:0] pin_hist_reg;

  assign nc_halt = low_speed_mode_in && (nc_reg == NC_DIV2 || nc_reg == NC_DIV4);

  always_comb begin
    case (nc_code_t'(nc_reg))
      NC_DIV2: nc_limit = NC_DIV_2;
      NC_DIV4: nc_limit = NC_DIV_4;
      NC_SLOW: nc_limit = NC_DIV_256;
      default: nc_limit = 8'h00;
    endcase
  end

  // Low clock /2 when slow: low_freq_tick is a pulse at the low clock rate
  // Greater-or-equal lets a shorter interval start at once after a code change
  assign nc_tick = (nc_reg == NC_OFF) ? 1'b1 :
                   (low_speed_mode_in && nc_reg == NC_SLOW) ? (low_freq_tick_in && nc_div_reg[0]) :
                   (nc_div_reg >= nc_limit);

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nc_div_reg <= 8'h00;
    end else if (low_speed_mode_in && nc_reg == NC_SLOW) begin
      nc_div_reg <= low_freq_tick_in ? {7'h00, ~nc_div_reg[0]} : nc_div_reg;
    end else if (nc_tick || nc_halt) begin
      nc_div_reg <= 8'h00;
    end else begin
      nc_div_reg <= nc_div_reg + 8'h01;
    end
  end

  // Three equal samples accepted; a glitch shorter than two intervals is dropped
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_hist_reg     <= 2'h0;
      filtered_pin_out <= 1'b0;
    end else if (nc_halt) begin
      pin_hist_reg     <= pin_hist_reg;
      filtered_pin_out <= filtered_pin_out;
    end else if (nc_reg == NC_OFF) begin
      pin_hist_reg     <= {2{timer_pin_in}};
      filtered_pin_out <= timer_pin_in;
    end else if (nc_tick) begin
      pin_hist_reg <= {pin_hist_reg[0], timer_pin_in};
      if (pin_hist_reg == {2{timer_pin_in}}) begin
        filtered_pin_out <= timer_pin_in;
      end
    end
  end

  // ==========================================================================
  // Control outputs
  // ==========================================================================
  logic auto_mode_ok;

  assign auto_mode_ok = timer_mode_in == MODE_TIMER_A || timer_mode_in == MODE_TIMER_B ||
                        timer_mode_in == MODE_EVENT || timer_mode_in == MODE_EXTTRIG ||
                        timer_mode_in == MODE_WINDOW;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_out <= '0;
    end else begin
      ctrl_out.run            <= run_reg;
      ctrl_out.flipflop_level <= ff_reg;
      ctrl_out.auto_capture   <= auto_reg && auto_mode_ok;
      ctrl_out.one_shot       <= auto_reg && timer_mode_in == MODE_PPG;
      ctrl_out.filter_tick    <= nc_tick && !nc_halt;
      ctrl_out.filter_halt    <= nc_halt;
    end
  end

  // ==========================================================================
  // Status flags, cleared by a read; a new event in the read cycle survives
  // ==========================================================================
  logic       flags_rd;
  logic       ev_ovf;
  logic       ev_cpa;
  logic       ev_cpb;
  logic       ovf_reg;
  logic       cpa_reg;
  logic       cpb_reg;

  assign flags_rd = rd_en && hit && word_index[7:0] == FLAGS_INDEX;
  assign ev_ovf   = events_in.overflow;
  assign ev_cpa   = events_in.width_capture && double_edge_in;
  assign ev_cpb   = (events_in.single_capture && !double_edge_in) ||
                    (events_in.duty_capture && double_edge_in);

  // Writes to the flag register are not decoded at all
  // A flag clears only when the read returned it set: read data is taken at the setup
  // edge, so an event landing there must survive to the next read
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ovf_reg <= FLAGS_RESET[FLAG_OVF_POS];
    end else if (ev_ovf) begin
      ovf_reg <= 1'b1;
    end else if (flags_rd && prdata_out[FLAG_OVF_POS]) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpa_reg <= FLAGS_RESET[FLAG_CPA_POS];
    end else if (ev_cpa) begin
      cpa_reg <= 1'b1;
    end else if (flags_rd && prdata_out[FLAG_CPA_POS]) begin
      cpa_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpb_reg <= FLAGS_RESET[FLAG_CPB_POS];
    end else if (ev_cpb) begin
      cpb_reg <= 1'b1;
    end else if (flags_rd && prdata_out[FLAG_CPB_POS]) begin
      cpb_reg <= 1'b0;
    end
  end

  // Overflow interrupt request to the interrupt controller
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= ev_ovf && ove_reg;
    end
  end

  // ==========================================================================
  // Interrupt status, enable and clear
  // ==========================================================================
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set[IRQ_OVF_POS] = ev_ovf && ove_reg;
  assign irq_set[IRQ_CPA_POS] = ev_cpa;
  assign irq_set[IRQ_CPB_POS] = ev_cpb;
  assign irq_clr = (wr_en && hit && word_index[7:0] == IRQ_CLR_INDEX) ?
                   pwdata_in[IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
    end else if (wr_en && hit && word_index[7:0] == IRQ_EN_INDEX) begin
      irq_en_reg <= pwdata_in[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [7:0] ctrl_rd;
  logic [7:0] flags_rd_val;

  always_comb begin
    ctrl_rd                      = 8'h00;
    ctrl_rd[CTRL_RUN_POS]        = run_reg;
    ctrl_rd[CTRL_AUTO_POS]       = auto_reg;
    ctrl_rd[CTRL_NC_LSB +: 2]    = nc_reg;
    ctrl_rd[CTRL_FF_POS]         = ff_reg;
    ctrl_rd[CTRL_OVE_POS]        = ove_reg;
    flags_rd_val                 = 8'h00;
    flags_rd_val[FLAG_OVF_POS]   = ovf_reg;
    flags_rd_val[FLAG_CPA_POS]   = cpa_reg;
    flags_rd_val[FLAG_CPB_POS]   = cpb_reg;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      // Unmapped words read zero, whatever their low address bits
      case (hit ? word_index[7:0] : 8'h00)
        CTRL_INDEX:     prdata_out <= {24'h00_0000, ctrl_rd};
        FLAGS_INDEX:    prdata_out <= {24'h00_0000, flags_rd_val};
        IRQ_STAT_INDEX: prdata_out <= {29'h0, irq_stat_reg};
        IRQ_EN_INDEX:   prdata_out <= {29'h0, irq_en_reg};
        EVENT_INDEX:    prdata_out <= {16'h0000, count_out};
        default:        prdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> src/timer_regs_pkg.sv
// Package: register map, field layout, reset values and codes of the timer control block
package timer_regs_pkg;

  // ==========================================================================
  // Register map (printed offsets are not all multiples of four: indices)
  // ==========================================================================
  localparam logic [7:0] CTRL_INDEX     = 8'h32;
  localparam logic [7:0] FLAGS_INDEX    = 8'h33;
  localparam logic [7:0] IRQ_STAT_INDEX = 8'h34;
  localparam logic [7:0] IRQ_EN_INDEX   = 8'h35;
  localparam logic [7:0] IRQ_CLR_INDEX  = 8'h36;
  localparam logic [7:0] EVENT_INDEX    = 8'h37;
  localparam int unsigned ADDR_W        = 12;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int unsigned CTRL_RUN_POS  = 0;
  localparam int unsigned CTRL_AUTO_POS = 1;
  localparam int unsigned CTRL_NC_LSB   = 4;
  localparam int unsigned CTRL_FF_POS   = 6;
  localparam int unsigned CTRL_OVE_POS  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h40;

  // Status register fields
  localparam int unsigned FLAG_OVF_POS  = 7;
  localparam int unsigned FLAG_CPA_POS  = 1;
  localparam int unsigned FLAG_CPB_POS  = 0;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;

  // Interrupt status bits
  localparam int unsigned IRQ_OVF_POS   = 0;
  localparam int unsigned IRQ_CPA_POS   = 1;
  localparam int unsigned IRQ_CPB_POS   = 2;
  localparam int unsigned IRQ_W         = 3;

  // Noise filter codes and dividers
  typedef enum logic [1:0] {
    NC_OFF  = 2'h0,
    NC_DIV2 = 2'h1,
    NC_DIV4 = 2'h2,
    NC_SLOW = 2'h3
  } nc_code_t;
  localparam logic [7:0] NC_DIV_2   = 8'h01;
  localparam logic [7:0] NC_DIV_4   = 8'h03;
  localparam logic [7:0] NC_DIV_256 = 8'hFF;

  // Operating mode codes of the companion mode register
  localparam logic [2:0] MODE_TIMER_A = 3'h0;
  localparam logic [2:0] MODE_TIMER_B = 3'h1;
  localparam logic [2:0] MODE_EVENT   = 3'h2;
  localparam logic [2:0] MODE_PPG     = 3'h3;
  localparam logic [2:0] MODE_EXTTRIG = 3'h4;
  localparam logic [2:0] MODE_WINDOW  = 3'h5;

  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Overflow and capture events from the datapath
  typedef struct packed {
    logic overflow;
    logic width_capture;
    logic single_capture;
    logic duty_capture;
  } timer_events_t;

  // Control outputs toward the datapath
  typedef struct packed {
    logic       run;
    logic       flipflop_level;
    logic       auto_capture;
    logic       one_shot;
    logic       filter_tick;
    logic       filter_halt;
  } timer_ctrl_t;

endpackage

// >>> sim/timer_control_status_regs_asserts.sv
// Concurrent checks on the ports of the timer control and status registers
`timescale 1ns/1ns
module timer_control_status_regs_asserts
  import timer_regs_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk_in,
  input wire logic              arst_n_in,
  // APB slave
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic              pready_out,
  input wire logic [31:0]       prdata_out,
  input wire logic              pslverr_out,
  // Datapath side
  input wire timer_events_t     events_in,
  input wire timer_ctrl_t       ctrl_out,
  input wire logic [15:0]       count_out,
  input wire logic              filtered_pin_out,
  input wire logic              timer_irq_out,
  input wire logic              irq_out
);
  // ==========================================================================
  // Setup
  // ==========================================================================
  localparam logic [ADDR_W-1:0] CTRL_ADDR  = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = {2'h0, FLAGS_INDEX, 2'h0};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Zero after a stop is excluded, so only genuine steps are judged
  a_count_step: assert property (($changed(count_out) && count_out != 16'h0) |->
    count_out == $past(count_out) + 16'h1)
    else $error("counter moved by other than one");
  a_stop_clears: assert property ((!ctrl_out.run) [*3] |-> count_out == 16'h0)
    else $error("counter not zero while stopped");
  a_ctrl_pad: assert property ((pready_out && !pwrite_in && paddr_in == CTRL_ADDR) |->
    (prdata_out[3:2] == 2'h0 && prdata_out[31:8] == 24'h0))
    else $error("control unused bits not zero");
  a_flags_pad: assert property ((pready_out && !pwrite_in && paddr_in == FLAGS_ADDR) |->
    (prdata_out[6:2] == 5'h00 && prdata_out[31:8] == 24'h0))
    else $error("flags unused bits not zero");
  a_tirq_cause: assert property (timer_irq_out |-> $past(events_in.overflow))
    else $error("timer interrupt without overflow");
  a_halt_blocks: assert property (ctrl_out.filter_halt [*3] |-> $stable(filtered_pin_out))
    else $error("halted filter passed the pin");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (pslverr_out |-> (pready_out && psel_in && penable_in))
    else $error("error outside an access cycle");

  c_unmapped: cover property (pready_out && pslverr_out);
  c_tirq: cover property (timer_irq_out);
  c_irq: cover property (irq_out);
  c_halt: cover property (ctrl_out.filter_halt);
endmodule

bind timer_control_status_regs timer_control_status_regs_asserts chk_i (
  .ref_clk_in       (ref_clk_in),
  .arst_n_in        (arst_n_in),
  .psel_in          (psel_in),
  .penable_in       (penable_in),
  .pwrite_in        (pwrite_in),
  .paddr_in         (paddr_in),
  .pready_out       (pready_out),
  .prdata_out       (prdata_out),
  .pslverr_out      (pslverr_out),
  .events_in        (events_in),
  .ctrl_out         (ctrl_out),
  .count_out        (count_out),
  .filtered_pin_out (filtered_pin_out),
  .timer_irq_out    (timer_irq_out),
  .irq_out          (irq_out)
);

// >>> sim/tb_timer_control_status_regs.sv
// Self-checking bench for the timer control and status registers
`timescale 1ns/1ns
module tb_timer_control_status_regs
  import timer_regs_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic              clk = 1'h0;
  logic              arst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              deep_stop, low_speed, lf_tick, dbl, pin, filt, tirq, irq;
  logic [2:0]        mode;
  logic [3:0]        tick_div;
  logic [15:0]       count, c1;
  logic              halted, fexp, e;
  logic [31:0]       r;
  timer_events_t     ev;
  timer_ctrl_t       ctrl;
  int                err_count, checked, tirq_cnt, n0;

  timer_control_status_regs dut (
    .ref_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .deep_stop_in(deep_stop), .low_speed_mode_in(low_speed), .low_freq_tick_in(lf_tick),
    .timer_mode_in(mode), .double_edge_in(dbl), .events_in(ev), .timer_pin_in(pin),
    .ctrl_out(ctrl), .count_out(count), .filtered_pin_out(filt),
    .timer_irq_out(tirq), .irq_out(irq));

  always #4 clk = ~clk;
  // Low clock tick every 16 cycles keeps the slow filter path short
  always @(posedge clk) begin
    tick_div <= tick_div + 4'h1;
    lf_tick  <= (tick_div == 4'h7);
    if (tirq === 1'h1) tirq_cnt <= tirq_cnt + 1;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'h1; pwrite <= w; paddr <= {2'h0, idx, 2'h0}; pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin chk("pready", 32'h1, 32'h0); results(); end
    rd = prdata; er = pslverr; psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x; logic y;
    apb(1'h1, idx, d, x, y);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x; logic y;
    apb(1'h0, idx, 32'h0, x, y);
    chk(nm, exp, x);
  endtask
  task automatic pulse(input logic [3:0] k);
    ev <= timer_events_t'(k); @(posedge clk); ev <= '0; repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    chk("timeout", 32'h0, 32'h1);
    results();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    arst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = '0; pwdata = 32'h0;
    deep_stop = 1'h0; low_speed = 1'h0; lf_tick = 1'h0; dbl = 1'h0; pin = 1'h0; fexp = 1'h0;
    mode = MODE_TIMER_A; tick_div = 4'h0; ev = '0; tirq_cnt = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    rdc("ctrl_reset", CTRL_INDEX, 32'h40);
    rdc("flags_reset", FLAGS_INDEX, 32'h0);
    chk("ff_level", 32'h1, 32'(ctrl.flipflop_level));
    wr(CTRL_INDEX, 32'hFF);
    rdc("ctrl_run", CTRL_INDEX, 32'hF3);
    c1 = count; repeat (5) @(posedge clk);
    chk("count_step", 32'(c1) + 32'h5, 32'(count));
    chk("run_out", 32'h1, 32'(ctrl.run));
    for (int m = 0; m < 6; m++) begin
      mode <= 3'(m); repeat (3) @(posedge clk);
      chk("auto_cap", 32'(m != 3), 32'(ctrl.auto_capture));
      chk("one_shot", 32'(m == 3), 32'(ctrl.one_shot));
    end
    mode <= MODE_TIMER_A;
    wr(CTRL_INDEX, 32'h01);
    rdc("ctrl_locked", CTRL_INDEX, 32'hF1);
    wr(CTRL_INDEX, 32'h00); repeat (3) @(posedge clk);
    chk("count_stop", 32'h0, 32'(count));
    rdc("ctrl_stop", CTRL_INDEX, 32'hF0);
    wr(CTRL_INDEX, 32'h00);
    rdc("ctrl_open", CTRL_INDEX, 32'h00);
    repeat (3) @(posedge clk);
    chk("ff_clear", 32'h0, 32'(ctrl.flipflop_level));
    wr(CTRL_INDEX, 32'h01); deep_stop <= 1'h1; repeat (2) @(posedge clk); deep_stop <= 1'h0;
    rdc("deep_stop", CTRL_INDEX, 32'h00);
    wr(CTRL_INDEX, 32'h01);
    rdc("restart", CTRL_INDEX, 32'h01);
    wr(CTRL_INDEX, 32'h00);
    // Long waits cover three samples even at the slowest interval
    for (int ls = 0; ls < 2; ls++) begin
      for (int c = 0; c < 4; c++) begin
        halted = (ls == 1) && (c == 1 || c == 2);
        wr(CTRL_INDEX, {26'h0, c[1:0], 4'h0});
        low_speed <= ls[0]; pin <= ~pin;
        if (!halted) fexp = ~pin;
        repeat (900) @(posedge clk);
        chk("filter_halt", 32'(halted), 32'(ctrl.filter_halt));
        chk("filter_out", 32'(fexp), 32'(filt));
        if (c == 0 || halted) chk("filter_tick", 32'(!halted), 32'(ctrl.filter_tick));
      end
    end
    low_speed <= 1'h0; wr(CTRL_INDEX, 32'h00);
    pulse(4'h8); rdc("ovf", FLAGS_INDEX, 32'h80);
    rdc("ovf_clear", FLAGS_INDEX, 32'h00);
    pulse(4'h2); rdc("cap_single", FLAGS_INDEX, 32'h01);
    dbl <= 1'h1; pulse(4'h4); rdc("cap_width", FLAGS_INDEX, 32'h02);
    pulse(4'h1); rdc("cap_duty", FLAGS_INDEX, 32'h01);
    pulse(4'hD); wr(FLAGS_INDEX, 32'hFF);
    rdc("flags_wr", FLAGS_INDEX, 32'h83);
    rdc("flags_clear", FLAGS_INDEX, 32'h00);
    // An overflow at the setup edge of a flags read is not shown, so it must be kept
    fork
      pulse(4'h8);
      rdc("ovf_race", FLAGS_INDEX, 32'h00);
    join
    rdc("ovf_kept", FLAGS_INDEX, 32'h80);
    wr(IRQ_CLR_INDEX, 32'h7); wr(IRQ_EN_INDEX, 32'h7); wr(CTRL_INDEX, 32'h80);
    chk("irq_idle", 32'h0, 32'(irq));
    n0 = tirq_cnt; pulse(4'h8);
    chk("tirq_on", 32'h1, 32'(tirq_cnt - n0));
    chk("irq_set", 32'h1, 32'(irq));
    rdc("irq_stat", IRQ_STAT_INDEX, 32'h1);
    wr(IRQ_CLR_INDEX, 32'h1); repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, 32'(irq));
    wr(CTRL_INDEX, 32'h00);
    n0 = tirq_cnt; pulse(4'h8);
    chk("tirq_off", 32'h0, 32'(tirq_cnt - n0));
    rdc("irq_stat_off", IRQ_STAT_INDEX, 32'h0);
    wr(IRQ_EN_INDEX, 32'h0); pulse(4'h4);
    rdc("irq_masked", IRQ_STAT_INDEX, 32'h2);
    chk("irq_mask", 32'h0, 32'(irq));
    wr(IRQ_EN_INDEX, 32'h2); repeat (2) @(posedge clk);
    chk("irq_unmask", 32'h1, 32'(irq));
    wr(IRQ_CLR_INDEX, 32'h7);
    rdc("irq_stat_clr", IRQ_STAT_INDEX, 32'h0);
    rdc("irq_clr_rd", IRQ_CLR_INDEX, 32'h0);
    rdc("count_reg", EVENT_INDEX, 32'h0);
    apb(1'h0, 8'h10, 32'h0, r, e);
    chk("unmapped", 32'h1, 32'(e));
    results();
  end
endmodule
